/* rtl/iofsm_cfg.svh */
// constants for the io function select mux
`ifndef IOFSM_CFG_SVH
`define IOFSM_CFG_SVH
`define IOFSM_SEL_W 2
`define IOFSM_FN0 2'h0
`define IOFSM_FN1 2'h1
`define IOFSM_FN2 2'h2
`define IOFSM_HP_PINS 22
`define IOFSM_LP_PINS 8
`define IOFSM_USB_DM 10
`define IOFSM_USB_DP 11
`define IOFSM_CS0_PIN 14
`define IOFSM_CS1_PIN 15
`define IOFSM_CS_HI 5
`define IOFSM_LP_UART_IN 4'h0
`define IOFSM_USB_SEL 2'h3
`define IOFSM_RST_SEL 2'h1
`endif

/* rtl/iofsm_io_function_select_mux.sv */
// top of the io function select mux, high-power and low-power pins
//------------------------------
// Functional notes
// - each high-power pin offers up to three functions 0 to 2, each with a direction type; pins 10 and 11 add usb as select 3.
// - type letters: I reads the pin, O drives it, T allows high impedance via output enable.
// - an input_default_high function sees a constant 1 when its pin selects another function.
// - a default-low input function sees a constant 0 when its pin selects another function.
// - every pin offers gpio and pins 0 to 7 additionally offer low-power gpio.
// - gpio14 function 2 is fast_serial_chip_select_0, bidirectional, input default 1.
// - gpio15 to gpio19 function 2 drive chip selects 1 to 5, output and tri-state only.
// - in deep sleep the high-power mux is inactive and the low-power mux routes lp pins.
// - the low-power mux lets two lp signals, lp gpio and one lp peripheral signal, share one pin during deep sleep.
// - each lp pin is low_power_gpio or a low-power peripheral signal.
// - lp pins 0..7: function 0 is lp gpio n, function 1 dtr dsr rts cts rxd txd sda scl.
// - lp function selects are indexed by low-power gpio number.
// - the usb data pins leave reset on the usb serial/debug controller until reconfigured.
//------------------------------
`timescale 1ns/100ps
`include "iofsm_cfg.svh"
module iofsm_io_function_select_mux
	import iofsm_pkg::*;
#(
	parameter int HP_PINS = `IOFSM_HP_PINS,
	parameter int LP_PINS = `IOFSM_LP_PINS
)(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// configuration
	input wire logic deep_sleep_in,
	input wire logic sel_we_in,
	input wire logic [4:0] sel_idx_in,
	input wire iofsm_pkg::iofsm_sel_t sel_data_in,
	input wire logic lp_sel_we_in,
	input wire logic [2:0] lp_sel_idx_in,
	input wire logic lp_sel_data_in,
	// high-power pins
	input wire logic [HP_PINS-1:0] pin_in,
	output logic [HP_PINS-1:0] pin_out,
	output logic [HP_PINS-1:0] pin_oe_out,
	// high-power functions
	input wire logic [HP_PINS-1:0] f0_out_in,
	input wire logic [HP_PINS-1:0] f0_oe_in,
	output logic [HP_PINS-1:0] f0_in_out,
	input wire logic [HP_PINS-1:0] gpio_out_in,
	input wire logic [HP_PINS-1:0] gpio_oe_in,
	output logic [HP_PINS-1:0] gpio_in_out,
	input wire logic [HP_PINS-1:0] f2_out_in,
	input wire logic [HP_PINS-1:0] f2_oe_in,
	output logic [HP_PINS-1:0] f2_in_out,
	// usb serial/debug controller on its pins
	input wire logic [1:0] usb_out_in,
	input wire logic [1:0] usb_oe_in,
	output logic [1:0] usb_in_out,
	// low-power pins
	input wire logic [LP_PINS-1:0] lp_pin_in,
	output logic [LP_PINS-1:0] lp_pin_out,
	output logic [LP_PINS-1:0] lp_pin_oe_out,
	// low-power functions
	input wire logic [LP_PINS-1:0] low_power_gpio_out_in,
	input wire logic [LP_PINS-1:0] low_power_gpio_oe_in,
	output logic [LP_PINS-1:0] low_power_gpio_in_out,
	input wire logic [LP_PINS-1:0] lp_periph_out_in,
	input wire logic [LP_PINS-1:0] lp_periph_oe_in,
	output logic [LP_PINS-1:0] lp_periph_in_out,
	// current selections
	output iofsm_pkg::iofsm_sel_t [HP_PINS-1:0] sel_out,
	output logic [LP_PINS-1:0] lp_sel_out
);
	import iofsm_pkg::*;

	//------------------------------
	// select registers
	//------------------------------
	iofsm_sel_t [HP_PINS-1:0] sel_q, sel_d;
	logic [LP_PINS-1:0] lp_sel_q, lp_sel_d;
	logic sleep_q, sleep_d;

	always_comb
	begin
		sel_d = sel_q;
		lp_sel_d = lp_sel_q;
		sleep_d = deep_sleep_in;
		if (sel_we_in && (32'(sel_idx_in) < HP_PINS))
			sel_d[sel_idx_in] = sel_data_in;
		if (lp_sel_we_in)
			lp_sel_d[lp_sel_idx_in] = lp_sel_data_in;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			for (int i = 0; i < HP_PINS; i++)
				sel_q[i] <= `IOFSM_RST_SEL;
			sel_q[`IOFSM_USB_DM] <= `IOFSM_USB_SEL;
			sel_q[`IOFSM_USB_DP] <= `IOFSM_USB_SEL;
			lp_sel_q <= '0;
			sleep_q <= 1'b0;
		end
		else
		begin
			sel_q <= sel_d;
			lp_sel_q <= lp_sel_d;
			sleep_q <= sleep_d;
		end
	end

	assign sel_out = sel_q;
	assign lp_sel_out = lp_sel_q;

	//------------------------------
	// high-power slices
	//------------------------------
	logic [HP_PINS-1:0] hp_pin, hp_oe;

	genvar g;
	generate
		for (g = 0; g < HP_PINS; g++)
		begin : g_hp
			iofsm_pin_slice #(
				.F0_DEF_HIGH(1'b1),
				.F2_PRESENT(g >= `IOFSM_CS0_PIN && g <= `IOFSM_CS0_PIN + `IOFSM_CS_HI),
				.F2_HAS_IN(g == `IOFSM_CS0_PIN)
			) u_slice (
				.pin_in(pin_in[g]),
				.pin_out(hp_pin[g]),
				.pin_oe_out(hp_oe[g]),
				.sel_in(sel_q[g]),
				.active_in(~sleep_q),
				.f0_out_in(f0_out_in[g]),
				.f0_oe_in(f0_oe_in[g]),
				.f0_in_out(f0_in_out[g]),
				.gpio_out_in(gpio_out_in[g]),
				.gpio_oe_in(gpio_oe_in[g]),
				.gpio_in_out(gpio_in_out[g]),
				.f2_out_in(f2_out_in[g]),
				.f2_oe_in(f2_oe_in[g]),
				.f2_in_out(f2_in_out[g])
			);
		end
	endgenerate

	//------------------------------
	// usb pins and pin outputs
	//------------------------------
	always_comb
	begin
		pin_out = hp_pin;
		pin_oe_out = hp_oe;
		usb_in_out = 2'h0;
		for (int u = 0; u < 2; u++)
		begin
			if (!sleep_q && sel_q[`IOFSM_USB_DM + u] == `IOFSM_USB_SEL)
			begin
				pin_out[`IOFSM_USB_DM + u] = usb_out_in[u];
				pin_oe_out[`IOFSM_USB_DM + u] = usb_oe_in[u];
				usb_in_out[u] = pin_in[`IOFSM_USB_DM + u];
			end
		end
	end

	//------------------------------
	// low-power mux
	//------------------------------
	always_comb
	begin
		lp_pin_out = '0;
		lp_pin_oe_out = '0;
		low_power_gpio_in_out = '0;
		lp_periph_in_out = '1; // idle levels for uart and i2c inputs
		if (sleep_q)
		begin
			for (int l = 0; l < LP_PINS; l++)
			begin
				if (!lp_sel_q[l])
				begin
					lp_pin_out[l] = low_power_gpio_out_in[l];
					lp_pin_oe_out[l] = low_power_gpio_oe_in[l];
					low_power_gpio_in_out[l] = lp_pin_in[l];
				end
				else
				begin
					lp_pin_out[l] = lp_periph_out_in[l];
					lp_pin_oe_out[l] = lp_periph_oe_in[l];
					lp_periph_in_out[l] = lp_pin_in[l];
				end
			end
		end
	end

	//------------------------------
	// checks
	//------------------------------
	property p_cs_in_default;
		@(posedge ref_clk_in) disable iff (reset_in)
		(sel_q[`IOFSM_CS0_PIN] != `IOFSM_FN2 || sleep_q) |-> f2_in_out[`IOFSM_CS0_PIN];
	endproperty
	a_cs_in_default: assert property (p_cs_in_default) else $error("cs0 input not high");

	property p_cs1_no_in;
		@(posedge ref_clk_in) disable iff (reset_in)
		1'b1 |-> f2_in_out[`IOFSM_CS1_PIN];
	endproperty
	a_cs1_no_in: assert property (p_cs1_no_in) else $error("cs1 has input path");

	property p_gpio_default;
		@(posedge ref_clk_in) disable iff (reset_in)
		(sel_q[0] != `IOFSM_FN1) |-> !gpio_in_out[0];
	endproperty
	a_gpio_default: assert property (p_gpio_default) else $error("gpio input not low");

	property p_f0_default;
		@(posedge ref_clk_in) disable iff (reset_in)
		(sel_q[1] != `IOFSM_FN0) |-> f0_in_out[1];
	endproperty
	a_f0_default: assert property (p_f0_default) else $error("f0 input not high");

	property p_sleep_off;
		@(posedge ref_clk_in) disable iff (reset_in)
		sleep_q |-> (pin_oe_out == '0);
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("hp pin driven in sleep");

	property p_lp_awake;
		@(posedge ref_clk_in) disable iff (reset_in)
		!sleep_q |-> (lp_pin_oe_out == '0);
	endproperty
	a_lp_awake: assert property (p_lp_awake) else $error("lp pin driven awake");

	property p_sel_write;
		@(posedge ref_clk_in) disable iff (reset_in)
		(sel_we_in && sel_idx_in == 5'h00) |=> (sel_q[0] == $past(sel_data_in));
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("select not updated");

	property p_lp_route;
		@(posedge ref_clk_in) disable iff (reset_in)
		(sleep_q && !lp_sel_q[0]) |-> (lp_pin_out[0] == low_power_gpio_out_in[0]);
	endproperty
	a_lp_route: assert property (p_lp_route) else $error("lp gpio not routed");

	property p_usb_reset;
		@(posedge ref_clk_in)
		reset_in |=> (sel_q[`IOFSM_USB_DM] == `IOFSM_USB_SEL && sel_q[`IOFSM_USB_DP] == `IOFSM_USB_SEL);
	endproperty
	a_usb_reset: assert property (p_usb_reset) else $error("usb pins not default");
endmodule

/* rtl/iofsm_pin_slice.sv */
// one high-power pin: function select and routing
`timescale 1ns/100ps
`include "iofsm_cfg.svh"
module iofsm_pin_slice
	import iofsm_pkg::*;
#(
	parameter bit F0_DEF_HIGH = 1'b1,
	parameter bit F2_PRESENT = 1'b0,
	parameter bit F2_HAS_IN = 1'b1
)(
	// pin side
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_out,
	// selection
	input wire iofsm_pkg::iofsm_sel_t sel_in,
	input wire logic active_in,
	// function 0
	input wire logic f0_out_in,
	input wire logic f0_oe_in,
	output logic f0_in_out,
	// gpio function 1
	input wire logic gpio_out_in,
	input wire logic gpio_oe_in,
	output logic gpio_in_out,
	// function 2
	input wire logic f2_out_in,
	input wire logic f2_oe_in,
	output logic f2_in_out
);
	import iofsm_pkg::*;

	always_comb
	begin
		pin_out = 1'b0;
		pin_oe_out = 1'b0;
		f0_in_out = F0_DEF_HIGH;
		gpio_in_out = 1'b0;
		f2_in_out = 1'b1;
		if (active_in)
		begin
			case (sel_in)
				`IOFSM_FN0:
				begin
					pin_out = f0_out_in;
					pin_oe_out = f0_oe_in;
					f0_in_out = pin_in;
				end
				`IOFSM_FN1:
				begin
					pin_out = gpio_out_in;
					pin_oe_out = gpio_oe_in;
					gpio_in_out = pin_in;
				end
				`IOFSM_FN2:
				begin
					if (F2_PRESENT)
					begin
						pin_out = f2_out_in;
						pin_oe_out = f2_oe_in;
						if (F2_HAS_IN)
							f2_in_out = pin_in;
					end
				end
				default:
				begin
					pin_oe_out = 1'b0;
				end
			endcase
		end
	end
endmodule

/* rtl/iofsm_pkg.sv */
// types for the io function select mux
package iofsm_pkg;
	typedef logic [1:0] iofsm_sel_t;
	typedef enum {iofsm_awake, iofsm_sleep} iofsm_mode_t;
endpackage

/* verification/iofsm_io_function_select_mux_tb_top.sv */
// self-checking bench for the io function select mux
`timescale 1ns/100ps
`include "iofsm_cfg.svh"
module iofsm_io_function_select_mux_tb_top;
	import iofsm_pkg::*;
	logic ref_clk_in = 0, reset_in = 1, deep_sleep_in = 0, sel_we_in = 0, lp_sel_we_in = 0, lp_sel_data_in = 0;
	logic [4:0] sel_idx_in = 0;
	logic [2:0] lp_sel_idx_in = 0;
	iofsm_sel_t sel_data_in = 0;
	logic [21:0] pin_in = 0, pin_out, pin_oe_out, f0o, f0e, f0_in_out, go, ge, gpio_in_out, f2o, f2e, f2_in_out;
	logic [1:0] uo, ue, usb_in_out;
	logic [7:0] lp_pin_in = 0, lp_pin_out, lp_pin_oe_out, lgo, lge, low_power_gpio_in_out;
	logic [7:0] lpo, lpe, lp_periph_in_out, lp_sel_out, lsh;
	iofsm_sel_t [21:0] sel_out, sh;
	logic slp;
	int mismatches = 0, n_checks = 0, cyc = 0;
	iofsm_io_function_select_mux iofsm_io_function_select_mux_inst (.ref_clk_in, .reset_in, .deep_sleep_in,
		.sel_we_in, .sel_idx_in, .sel_data_in, .lp_sel_we_in, .lp_sel_idx_in, .lp_sel_data_in, .pin_in, .pin_out,
		.pin_oe_out, .f0_out_in(f0o), .f0_oe_in(f0e), .f0_in_out, .gpio_out_in(go), .gpio_oe_in(ge), .gpio_in_out,
		.f2_out_in(f2o), .f2_oe_in(f2e), .f2_in_out, .usb_out_in(uo), .usb_oe_in(ue), .usb_in_out, .lp_pin_in,
		.lp_pin_out, .lp_pin_oe_out, .low_power_gpio_out_in(lgo), .low_power_gpio_oe_in(lge), .low_power_gpio_in_out,
		.lp_periph_out_in(lpo), .lp_periph_oe_in(lpe), .lp_periph_in_out, .sel_out, .lp_sel_out);
	iofsm_periph_model iofsm_periph_model_inst (.ref_clk_in, .f0_drv_out(f0o), .f0_en_out(f0e), .gpio_drv_out(go),
		.gpio_en_out(ge), .f2_drv_out(f2o), .f2_en_out(f2e), .usb_drv_out(uo), .usb_en_out(ue), .lpg_drv_out(lgo),
		.lpg_en_out(lge), .lpp_drv_out(lpo), .lpp_en_out(lpe));
	always #4 ref_clk_in = ~ref_clk_in;
	// expected selections, one edge after each write
	always @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			for (int i = 0; i < 22; i++)
				sh[i] = (i == 10 || i == 11) ? `IOFSM_USB_SEL : `IOFSM_RST_SEL;
			lsh = '0;
			slp = 1'b0;
		end
		else
		begin
			if (sel_we_in && sel_idx_in < 5'h16)
				sh[sel_idx_in] = sel_data_in;
			if (lp_sel_we_in)
				lsh[lp_sel_idx_in] = lp_sel_data_in;
			slp = deep_sleep_in;
		end
		cyc++;
		if (cyc == 5000)
		begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_all();
		logic [21:0] eo, ee, e0, eg, e2;
		logic [7:0] lo, le, lg, lp;
		logic [1:0] um;
		for (int i = 0; i < 22; i++)
		begin
			case (sh[i])
				2'h0: {eo[i], ee[i]} = {f0o[i], f0e[i]};
				2'h1: {eo[i], ee[i]} = {go[i], ge[i]};
				2'h2: {eo[i], ee[i]} = {f2o[i], f2e[i] && i >= 14 && i <= 19};
				default: {eo[i], ee[i]} = (i == 10 || i == 11) ? {uo[i[0]], ue[i[0]]} : 2'h0;
			endcase
			ee[i] = ee[i] && !slp;
			e0[i] = (!slp && sh[i] == 2'h0) ? pin_in[i] : 1'b1;
			eg[i] = (!slp && sh[i] == 2'h1) ? pin_in[i] : 1'b0;
			e2[i] = (!slp && sh[i] == 2'h2 && i == 14) ? pin_in[i] : 1'b1;
		end
		um = {!slp && sh[11] == 2'h3, !slp && sh[10] == 2'h3};
		for (int j = 0; j < 8; j++)
		begin
			le[j] = slp && (lsh[j] ? lpe[j] : lge[j]);
			lo[j] = lsh[j] ? lpo[j] : lgo[j];
			lg[j] = (slp && !lsh[j]) ? lp_pin_in[j] : 1'b0;
			lp[j] = (slp && lsh[j]) ? lp_pin_in[j] : 1'b1;
		end
		chk(64'(sel_out), 64'(sh));
		chk(64'(pin_oe_out), 64'(ee));
		chk(64'(pin_out & ee), 64'(eo & ee));
		chk(64'(f0_in_out), 64'(e0));
		chk(64'(gpio_in_out), 64'(eg));
		chk(64'(f2_in_out), 64'(e2));
		chk(64'(usb_in_out), 64'(pin_in[11:10] & um));
		chk(64'(lp_sel_out), 64'(lsh));
		chk(64'(lp_pin_oe_out), 64'(le));
		chk(64'(lp_pin_out & le), 64'(lo & le));
		chk(64'(low_power_gpio_in_out), 64'(lg));
		chk(64'(lp_periph_in_out), 64'(lp));
	endtask
	task automatic step(logic we, logic [4:0] idx, iofsm_sel_t d, logic lwe, logic [2:0] lidx, logic ld, logic ds);
		@(negedge ref_clk_in);
		check_all();
		{sel_we_in, sel_idx_in, sel_data_in, lp_sel_we_in, lp_sel_idx_in, lp_sel_data_in} = {we, idx, d, lwe, lidx, ld};
		deep_sleep_in = ds;
		pin_in = 22'($urandom);
		lp_pin_in = 8'($urandom);
	endtask
	initial
	begin
		void'($urandom(53663));
		repeat (20) @(negedge ref_clk_in);
		reset_in = 1'b0;
		step(1'b1, 5'h0e, 2'h2, 1'b0, 3'h0, 1'b0, 1'b0);
		step(1'b1, 5'h0f, 2'h2, 1'b1, 3'h7, 1'b1, 1'b0);
		step(1'b1, 5'h19, 2'h0, 1'b1, 3'h0, 1'b1, 1'b0);
		step(1'b1, 5'h00, 2'h3, 1'b0, 3'h0, 1'b0, 1'b0);
		step(1'b1, 5'h0a, 2'h1, 1'b0, 3'h0, 1'b0, 1'b1);
		repeat (3) step(1'b0, 5'h00, 2'h0, 1'b0, 3'h0, 1'b0, 1'b1);
		repeat (3000)
			step(1'($urandom), 5'($urandom), 2'($urandom), 1'($urandom), 3'($urandom), 1'($urandom),
				(($urandom % 16) == 0) ? !deep_sleep_in : deep_sleep_in);
		step(1'b0, 5'h00, 2'h0, 1'b0, 3'h0, 1'b0, 1'b0);
		reset_in = 1'b1;
		step(1'b0, 5'h00, 2'h0, 1'b0, 3'h0, 1'b0, 1'b0);
		reset_in = 1'b0;
		step(1'b0, 5'h00, 2'h0, 1'b0, 3'h0, 1'b0, 1'b0);
		wrap_up();
	end
endmodule

/* verification/iofsm_periph_model.sv */
// peripheral, gpio and usb controller side driving the mux function ports
`timescale 1ns/100ps
module iofsm_periph_model #(
	parameter int HP = 22,
	parameter int LP = 8
)(
	// clock
	input wire logic ref_clk_in,
	// high-power function drive
	output logic [HP-1:0] f0_drv_out,
	output logic [HP-1:0] f0_en_out,
	output logic [HP-1:0] gpio_drv_out,
	output logic [HP-1:0] gpio_en_out,
	output logic [HP-1:0] f2_drv_out,
	output logic [HP-1:0] f2_en_out,
	output logic [1:0] usb_drv_out,
	output logic [1:0] usb_en_out,
	// low-power function drive
	output logic [LP-1:0] lpg_drv_out,
	output logic [LP-1:0] lpg_en_out,
	output logic [LP-1:0] lpp_drv_out,
	output logic [LP-1:0] lpp_en_out
);
	initial
	begin
		{f0_drv_out, f0_en_out, gpio_drv_out, gpio_en_out, f2_drv_out, f2_en_out} = '0;
		{usb_drv_out, usb_en_out, lpg_drv_out, lpg_en_out, lpp_drv_out, lpp_en_out} = '0;
		// every function changes drive and enable each cycle
		forever
		begin
			@(negedge ref_clk_in);
			f0_drv_out <= HP'($urandom);
			f0_en_out <= HP'($urandom);
			gpio_drv_out <= HP'($urandom);
			gpio_en_out <= HP'($urandom);
			f2_drv_out <= HP'($urandom);
			f2_en_out <= HP'($urandom);
			usb_drv_out <= 2'($urandom);
			usb_en_out <= 2'($urandom);
			lpg_drv_out <= LP'($urandom);
			lpg_en_out <= LP'($urandom);
			lpp_drv_out <= LP'($urandom);
			lpp_en_out <= LP'($urandom);
		end
	end
endmodule
